// File: logic/cle_regs.vh
// Constants for the cascaded logic equation engine
// Operation
// - Four selectable input signals per equation
// - Each gate input individually invertible
// - Rise and fall delays after gate
// - Unlatched and latched outputs both provided
// - Latched output also offered inverted
// - Selectable latch clear, optionally inverted
// - Clear dominates set on latch
// - Equations evaluated in ascending index order
// - Evaluation pass repeats continuously
// - Equation outputs selectable as equation inputs
// - Lower producer gives same-pass result
// - Higher producer gives previous-pass result
// - Inputs and outputs readable for status
`ifndef CLE_REGS_VH
`define CLE_REGS_VH

// Array geometry
`define CLE_NUM_EQ 8
`define CLE_IDX_W 3
`define CLE_EXT_W 16
`define CLE_SIG_W 32
`define CLE_SEL_W 5
`define CLE_DLY_W 8

// Signal list layout: external, unlatched results, latched results
`define CLE_SIG_EXT_BASE 0
`define CLE_SIG_OUT_BASE 16
`define CLE_SIG_LAT_BASE 24

// Configuration word field positions
`define CLE_CFG_W 48
`define CLE_F_SEL0 0
`define CLE_F_INV 20
`define CLE_F_OP 24
`define CLE_F_RST_SEL 26
`define CLE_F_RST_INV 31
`define CLE_F_RISE 32
`define CLE_F_FALL 40
`define CLE_CFG_RESET 48'h0000_0000_0000

// Gate operator codes
`define CLE_OP_AND 2'h0
`define CLE_OP_OR 2'h1
`define CLE_OP_NAND 2'h2
`define CLE_OP_NOR 2'h3

`endif

// File: logic/cle_sync.v
// Two-stage synchroniser for a group of asynchronous levels
`default_nettype none

module cle_sync #(
   parameter W = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Asynchronous levels in, synchronised levels out
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);

   // First stage, read only by the second stage
   reg [W-1:0] meta_q;

   // Two flops cut metastability before any logic sees the level
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // cle_sync

`default_nettype wire

// File: logic/cle_cfg_mem.v
// Per-equation configuration memory with registered read data
`include "cle_regs.vh"
`default_nettype none

module cle_cfg_mem (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Write port from the configuration side
   input wire wr_en,
   input wire [`CLE_IDX_W-1:0] wr_addr,
   input wire [`CLE_CFG_W-1:0] wr_data,
   // Read port toward the evaluator
   input wire [`CLE_IDX_W-1:0] rd_addr,
   output reg [`CLE_CFG_W-1:0] rd_data
);

   // One configuration word per equation
   reg [`CLE_CFG_W-1:0] mem_q [0:`CLE_NUM_EQ-1];
   integer i;

   // Cleared at reset so an unconfigured equation is a harmless AND of signal 0
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `CLE_NUM_EQ; i = i + 1) begin
            mem_q[i] <= `CLE_CFG_RESET;
         end
         rd_data <= `CLE_CFG_RESET;
      end else begin
         if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
         end
         rd_data <= mem_q[rd_addr];
      end
   end

endmodule // cle_cfg_mem

`default_nettype wire

// File: logic/cle_engine.v
// Sequential evaluator for the cascaded logic equation array
`include "cle_regs.vh"
`default_nettype none

module cle_engine (
   // Clock and asynchronous reset
   input wire clk,
   input wire rst_b,
   // Status signals from protection functions, asynchronous
   input wire [`CLE_EXT_W-1:0] ext_sig,
   // Configuration write port, same clock domain
   input wire cfg_we,
   input wire [`CLE_IDX_W-1:0] cfg_idx,
   input wire [`CLE_CFG_W-1:0] cfg_wdata,
   // Status display selection, same clock domain
   input wire [`CLE_IDX_W-1:0] stat_idx,
   // Equation results toward relay drivers and blocking inputs
   output reg [`CLE_NUM_EQ-1:0] eq_out,
   output reg [`CLE_NUM_EQ-1:0] eq_latched,
   output reg [`CLE_NUM_EQ-1:0] eq_latched_n,
   // One-cycle pulse when a full pass has finished
   output reg pass_done,
   // Status display of the selected equation
   output reg [3:0] stat_inputs,
   output reg stat_gate,
   output reg stat_out,
   output reg stat_latched
);

   // Schedule of one pass, two cycles per equation:
   //   fetch n : the word of equation n is read from the memory; at n = 0 the
   //             synchronised status levels are frozen for the whole pass
   //   eval n  : equation n is worked out and its state written at the edge
   // With eight equations a pass takes sixteen cycles, and pass_done marks the
   // fetch of equation 0 that follows the evaluation of the last one.
   //
   // Age of what an equation reads:
   //   results of lower indices were written earlier in this same pass
   //   results of its own and of higher indices still hold the last pass
   //   status levels are the picture frozen at the start of the pass
   // A backward chain therefore costs one pass per step; users who need the
   // fastest path should number producers below their consumers.
   //
   // Timer: a change of the gate result is counted once per pass, and the
   // timed result follows only when the count has reached the delay chosen
   // for that direction; a delay of zero passes the change on in the same
   // pass. A change that goes away first restarts the count, so pulses that
   // are shorter than the delay never reach the outputs or the latch.
   //
   // Outputs are copies of the internal state, one cycle late, so that every
   // top-level output leaves a flip-flop.

   // State codes, one-hot
   localparam [1:0] S_FETCH = 2'h1;
   localparam [1:0] S_EVAL = 2'h2;
   // Last index worked out as an integer, then cut to pointer width on purpose
   localparam integer LAST_IDX_I = `CLE_NUM_EQ - 1;
   localparam [`CLE_IDX_W-1:0] LAST_IDX = LAST_IDX_I[`CLE_IDX_W-1:0];

   // Reset synchroniser stages
   reg rst_meta_q;
   reg rst_n_q;

   // Sequencer state and equation pointer
   reg [1:0] state_q;
   reg [`CLE_IDX_W-1:0] ptr_q;

   // External signals after synchronising, and their per-pass snapshot
   wire [`CLE_EXT_W-1:0] ext_sync;
   reg [`CLE_EXT_W-1:0] ext_q;

   // Per-equation state
   reg [`CLE_NUM_EQ-1:0] out_q;            // Timed unlatched result
   reg [`CLE_NUM_EQ-1:0] lat_q;            // Latched result
   reg [`CLE_NUM_EQ-1:0] gate_q;           // Raw gate result, for status
   reg [`CLE_DLY_W-1:0] cnt_q [0:`CLE_NUM_EQ-1]; // Pending-change pass count
   reg [3:0] cin_q [0:`CLE_NUM_EQ-1];      // Conditioned inputs, for status

   // Configuration word of the equation being evaluated
   wire [`CLE_CFG_W-1:0] cfg_rd;

   // Fields of the fetched word, named once so the evaluator reads plainly
   wire [4*`CLE_SEL_W-1:0] f_sel; // Four input selects
   wire [3:0] f_inv; // Per-input inversion
   wire [1:0] f_op; // Gate operator code
   wire [`CLE_SEL_W-1:0] f_rst_sel; // Latch clear select
   wire f_rst_inv; // Latch clear inversion
   wire [`CLE_DLY_W-1:0] f_rise; // Passes a rising change must last
   wire [`CLE_DLY_W-1:0] f_fall; // Passes a falling change must last

   // State of the equation under the pointer
   wire out_cur;
   wire lat_cur;
   wire [`CLE_DLY_W-1:0] cnt_cur;

   // Combinational evaluation results
   reg [`CLE_SIG_W-1:0] sigvec;
   reg [3:0] cin;
   reg gate;
   reg clr;
   reg tout;
   reg lat_d;
   reg [`CLE_DLY_W-1:0] dly;
   reg [`CLE_DLY_W-1:0] cnt_d;
   reg [`CLE_SEL_W-1:0] sel;
   integer k;
   integer j; // Loop index of the reset branch, kept apart from k

   // Reset released through two flops; assertion stays asynchronous
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Pin-level status signals come from other domains
   cle_sync #(
      .W(`CLE_EXT_W)
   ) u_sync (
      .clk(clk),
      .rst_b(rst_n_q),
      .async_in(ext_sig),
      .sync_out(ext_sync)
   );

   // Configuration words; read address follows the pointer during fetch
   cle_cfg_mem u_mem (
      .clk(clk),
      .rst_n(rst_n_q),
      .wr_en(cfg_we),
      .wr_addr(cfg_idx),
      .wr_data(cfg_wdata),
      .rd_addr(ptr_q),
      .rd_data(cfg_rd)
   );

   // Field split of the configuration word
   assign f_sel = cfg_rd[`CLE_F_SEL0 +: 4*`CLE_SEL_W];
   assign f_inv = cfg_rd[`CLE_F_INV +: 4];
   assign f_op = cfg_rd[`CLE_F_OP +: 2];
   assign f_rst_sel = cfg_rd[`CLE_F_RST_SEL +: `CLE_SEL_W];
   assign f_rst_inv = cfg_rd[`CLE_F_RST_INV];
   assign f_rise = cfg_rd[`CLE_F_RISE +: `CLE_DLY_W];
   assign f_fall = cfg_rd[`CLE_F_FALL +: `CLE_DLY_W];

   // Current equation's stored state, picked out by the pointer
   assign out_cur = out_q[ptr_q];
   assign lat_cur = lat_q[ptr_q];
   assign cnt_cur = cnt_q[ptr_q];

   // Evaluate the equation under the pointer
   always @* begin
      // Signal list: snapshot inputs, then live results of this pass
      sigvec = {lat_q, out_q, ext_q};
      // Each bit of out_q below the pointer was already rewritten this pass,
      // each bit above still holds the previous pass
      cin = 4'h0;
      sel = {`CLE_SEL_W{1'b0}};
      for (k = 0; k < 4; k = k + 1) begin
         sel = f_sel[k * `CLE_SEL_W +: `CLE_SEL_W];
         // Selected signal, inverted on request
         cin[k] = sigvec[sel] ^ f_inv[k];
      end
      // Gate operator
      case (f_op)
         `CLE_OP_AND: begin
            gate = &cin;
         end
         `CLE_OP_OR: begin
            gate = |cin;
         end
         `CLE_OP_NAND: begin
            gate = ~(&cin);
         end
         `CLE_OP_NOR: begin
            gate = ~(|cin);
         end
         default: begin
            gate = 1'b0;
         end
      endcase
      // Delay picked by the direction of the pending change
      dly = gate ? f_rise : f_fall;
      if (gate == out_cur) begin
         // Change withdrawn before its time: output stands, count restarts
         tout = out_cur;
         cnt_d = {`CLE_DLY_W{1'b0}};
      end else if (cnt_cur >= dly) begin
         // Change has persisted for the full number of passes
         tout = gate;
         cnt_d = {`CLE_DLY_W{1'b0}};
      end else begin
         // Count one more pass of the pending change
         tout = out_cur;
         cnt_d = cnt_cur + {{(`CLE_DLY_W-1){1'b0}}, 1'b1};
      end
      // Latch clear from the list, optionally inverted
      clr = sigvec[f_rst_sel] ^ f_rst_inv;
      // Clear dominates a simultaneous set
      if (clr) begin
         lat_d = 1'b0;
      end else if (tout) begin
         lat_d = 1'b1;
      end else begin
         lat_d = lat_cur;
      end
   end

   // Sequencer: fetch then evaluate each equation, wrapping without pause
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= S_FETCH;
         ptr_q <= {`CLE_IDX_W{1'b0}};
         ext_q <= {`CLE_EXT_W{1'b0}};
         pass_done <= 1'b0;
      end else begin
         pass_done <= 1'b0;
         case (state_q)
            S_FETCH: begin
               // External inputs frozen for a whole pass, so every equation
               // of one pass sees the same picture
               if (ptr_q == {`CLE_IDX_W{1'b0}}) begin
                  ext_q <= ext_sync;
               end
               state_q <= S_EVAL;
            end
            S_EVAL: begin
               state_q <= S_FETCH;
               if (ptr_q == LAST_IDX) begin
                  // Next pass starts right after the last equation
                  ptr_q <= {`CLE_IDX_W{1'b0}};
                  pass_done <= 1'b1;
               end else begin
                  // Strictly ascending index order
                  ptr_q <= ptr_q + {{(`CLE_IDX_W-1){1'b0}}, 1'b1};
               end
            end
            default: begin
               // Recover from an illegal code by restarting the pass
               state_q <= S_FETCH;
               ptr_q <= {`CLE_IDX_W{1'b0}};
            end
         endcase
      end
   end

   // Per-equation state is written only in the evaluate step
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         out_q <= {`CLE_NUM_EQ{1'b0}};
         lat_q <= {`CLE_NUM_EQ{1'b0}};
         gate_q <= {`CLE_NUM_EQ{1'b0}};
         for (j = 0; j < `CLE_NUM_EQ; j = j + 1) begin
            cnt_q[j] <= {`CLE_DLY_W{1'b0}};
            cin_q[j] <= 4'h0;
         end
      end else if (state_q == S_EVAL) begin
         // Result stored at once so later equations this pass see it
         out_q[ptr_q] <= tout;
         lat_q[ptr_q] <= lat_d;
         gate_q[ptr_q] <= gate;
         cnt_q[ptr_q] <= cnt_d;
         cin_q[ptr_q] <= cin;
      end
   end

   // Output flops: results mirrored one cycle after evaluation
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         eq_out <= {`CLE_NUM_EQ{1'b0}};
         eq_latched <= {`CLE_NUM_EQ{1'b0}};
         eq_latched_n <= {`CLE_NUM_EQ{1'b1}};
      end else begin
         // Plain and stored results side by side
         eq_out <= out_q;
         eq_latched <= lat_q;
         // Complement of the stored result
         eq_latched_n <= ~lat_q;
      end
   end

   // Status display follows live state of the selected equation
   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stat_inputs <= 4'h0;
         stat_gate <= 1'b0;
         stat_out <= 1'b0;
         stat_latched <= 1'b0;
      end else begin
         // Readable while the passes keep running
         stat_inputs <= cin_q[stat_idx];
         stat_gate <= gate_q[stat_idx];
         stat_out <= out_q[stat_idx];
         stat_latched <= lat_q[stat_idx];
      end
   end

endmodule // cle_engine

`default_nettype wire

// File: testbench/cle_engine_asserts.sv
// Port checks for the logic equation engine
`include "cle_regs.vh"
`default_nettype none
module cle_engine_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Status selection and results
   input wire logic [`CLE_IDX_W-1:0] stat_idx,
   input wire logic [`CLE_NUM_EQ-1:0] eq_out,
   input wire logic [`CLE_NUM_EQ-1:0] eq_latched,
   input wire logic [`CLE_NUM_EQ-1:0] eq_latched_n,
   input wire logic pass_done,
   input wire logic stat_out,
   input wire logic stat_latched
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // Two quiet cycles, so the status copy has caught up with the results
   sequence s_settled;
      $stable(stat_idx) && $stable(eq_out) && $stable(eq_latched) ##1
      $stable(stat_idx) && $stable(eq_out) && $stable(eq_latched);
   endsequence
   a_latch_inverse: assert property (eq_latched_n == ~eq_latched)
      else $error("inverted latch differs");
   a_pass_period: assert property (pass_done |-> ##16 pass_done)
      else $error("pass period wrong");
   a_pass_single: assert property (pass_done |=> !pass_done [*8])
      else $error("pass pulse too long");
   a_first_slot: assert property ($changed(eq_out[0]) |-> $past(pass_done, 3))
      else $error("first equation out of slot");
   a_last_slot: assert property ($changed(eq_out[7]) |-> $past(pass_done))
      else $error("last equation out of slot");
   a_change_once: assert property ($changed(eq_out[0]) |=> $stable(eq_out[0]) [*8])
      else $error("result changed twice in a pass");
   a_latch_set: assert property ((eq_latched & ~$past(eq_latched) & ~eq_out) == 8'h00)
      else $error("latch set without result");
   a_stat_out: assert property (s_settled |-> stat_out == eq_out[stat_idx])
      else $error("status result differs");
   a_stat_latch: assert property (s_settled |-> stat_latched == eq_latched[stat_idx])
      else $error("status latch differs");
endmodule // cle_engine_asserts
bind cle_engine cle_engine_asserts u_cle_engine_asserts (.clk(clk), .rst_b(rst_b),
   .stat_idx(stat_idx), .eq_out(eq_out), .eq_latched(eq_latched),
   .eq_latched_n(eq_latched_n), .pass_done(pass_done), .stat_out(stat_out),
   .stat_latched(stat_latched));
`default_nettype wire

// File: testbench/cle_prot_model.sv
// Behavioural source of protection status levels
`default_nettype none
module cle_prot_model (
   // Clock
   input wire logic clk,
   // Levels commanded by the bench
   input wire logic [15:0] want,
   // Status levels toward the engine
   output var logic [15:0] ext_sig
);
   timeunit 1ns;
   timeprecision 1ps;
   // Levels move off the sampling edge, like a source unrelated to it
   initial begin
      ext_sig = 16'h0000;
      forever @(negedge clk) ext_sig <= want;
   end
endmodule // cle_prot_model
`default_nettype wire

// File: testbench/test_cle_engine.sv
// Self-checking bench for the logic equation engine
`default_nettype none
module test_cle_engine;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic cfg_we = 1'b0;
   logic [2:0] cfg_idx = 3'h0;
   logic [47:0] cfg_wdata = 48'h0;
   logic [2:0] stat_idx = 3'h0;
   logic [15:0] want = 16'h0000;
   logic [15:0] ext_sig;
   logic [7:0] eq_out, eq_latched, eq_latched_n;
   logic pass_done, stat_gate, stat_out, stat_latched;
   logic [3:0] stat_inputs;
   int failures = 0;
   int cmp_count = 0;
   int cycles = 0;
   initial forever #5 clk = ~clk;
   cle_prot_model u_cle_prot_model (.clk(clk), .want(want), .ext_sig(ext_sig));
   cle_engine u_cle_engine (.clk(clk), .rst_b(rst_b), .ext_sig(ext_sig), .cfg_we(cfg_we),
      .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata), .stat_idx(stat_idx), .eq_out(eq_out),
      .eq_latched(eq_latched), .eq_latched_n(eq_latched_n), .pass_done(pass_done),
      .stat_inputs(stat_inputs), .stat_gate(stat_gate), .stat_out(stat_out),
      .stat_latched(stat_latched));
   task automatic give_verdict;
      if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Guard against a hang; the whole run needs about 4000 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         give_verdict();
      end
   end
   // Word: fall, rise, clear select with its inversion, operator, inversions, selects
   function automatic logic [47:0] cw(input logic [19:0] sel, input logic [3:0] inv,
      input logic [1:0] op, input logic [5:0] clr, input logic [7:0] ri, input logic [7:0] fa);
      return {fa, ri, clr, op, inv, sel};
   endfunction
   task automatic put(input logic [2:0] i, input logic [47:0] w);
      @(negedge clk);
      cfg_we = 1'b1;
      cfg_idx = i;
      cfg_wdata = w;
      @(negedge clk);
      cfg_we = 1'b0;
   endtask
   // Waits for the end of n passes; the hang guard bounds it
   task automatic passes(input int n);
      repeat (n) begin
         @(negedge clk);
         while (pass_done !== 1'b1) @(negedge clk);
      end
   endtask
   // Every operator against every input pattern, inputs 0 and 2 inverted
   task automatic t_gates;
      logic [3:0] v;
      logic g;
      stat_idx = 3'h0;
      for (int op = 0; op < 4; op++) begin
         put(3'h0, cw(20'h18820, 4'h5, op[1:0], 6'h00, 8'h00, 8'h00));
         for (int p = 0; p < 16; p++) begin
            want = {12'h000, p[3:0]};
            passes(3);
            v = p[3:0] ^ 4'h5;
            g = (op[0] ? |v : &v) ^ op[1];
            check("gate_inputs", {4'h0, stat_inputs}, {4'h0, v});
            check("gate_result", 8'(stat_gate), 8'(g));
            check("eq0_out", 8'(eq_out[0]), 8'(g));
         end
      end
   endtask
   // Equation 1 reads 0 (forward), equation 2 reads 3 (backward)
   task automatic t_cascade;
      want = 16'h0000;
      put(3'h0, 48'h0);
      put(3'h1, {28'h0, 20'h84210});
      put(3'h2, {28'h0, 20'h9CE73});
      put(3'h3, 48'h0);
      passes(3);
      want = 16'h0001;
      @(negedge clk);
      while (eq_out[0] !== 1'b1) @(negedge clk);
      passes(1);
      check("forward_chain", 8'(eq_out[3:0]), 8'h0B);
      passes(1);
      check("backward_chain", 8'(eq_out[3:0]), 8'h0F);
   endtask
   // Rise delay 3 and fall delay 2 passes; a short pulse must vanish
   task automatic t_timer;
      int n;
      logic seen;
      seen = 1'b0;
      want = 16'h0000;
      stat_idx = 3'h4;
      put(3'h4, cw(20'h08421, 4'h0, 2'h0, 6'h00, 8'h03, 8'h02));
      // An earlier high result must first fall through the two-pass delay
      passes(5);
      want = 16'h0002;
      repeat (20) @(negedge clk);
      want = 16'h0000;
      repeat (96) begin
         @(negedge clk);
         seen = seen | eq_out[4];
      end
      check("short_pulse", 8'(seen), 8'h00);
      for (int e = 1; e >= 0; e--) begin
         want = e ? 16'h0002 : 16'h0000;
         @(negedge clk);
         while (stat_gate !== e[0]) @(negedge clk);
         n = 0;
         while (eq_out[4] !== e[0] && n < 9) begin
            passes(1);
            n++;
         end
         check("delay_passes", 8'(n), e ? 8'h04 : 8'h03);
      end
   endtask
   // Set by input 2, clear by input 3; both at once must leave it clear
   task automatic t_latch;
      logic [15:0] pat [5] = '{16'h4, 16'h0, 16'h8, 16'hC, 16'hC};
      logic [1:0] exp [5] = '{2'h3, 2'h2, 2'h0, 2'h1, 2'h3};
      stat_idx = 3'h5;
      put(3'h5, cw(20'h10842, 4'h0, 2'h0, 6'h03, 8'h00, 8'h00));
      for (int s = 0; s < 5; s++) begin
         if (s == 4) put(3'h5, cw(20'h10842, 4'h0, 2'h0, 6'h23, 8'h00, 8'h00));
         want = pat[s];
         passes(3);
         check("latch", {6'h00, eq_latched[5], eq_out[5]}, {6'h00, exp[s]});
         check("latch_n", 8'(eq_latched_n[5]), {7'h00, !exp[s][1]});
         check("stat_latch", {6'h00, stat_latched, stat_out}, {6'h00, exp[s]});
      end
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      check("reset_out", eq_out, 8'h00);
      check("reset_latch_n", eq_latched_n, 8'hFF);
      t_gates();
      t_cascade();
      t_timer();
      t_latch();
      give_verdict();
   end
endmodule // test_cle_engine
`default_nettype wire
